//--- hw/multiply_negate_file_ops.sv
/*
 * Core datapath slice that executes the register multiply and the file
 * negate instructions against a local data memory, with an Avalon-MM
 * slave for software to load operands, issue instructions and read back
 * results. Assumes a single clock, clk_sys, and a synchronous reset.
 */
`timescale 1ns/100ps
`default_nettype none
module multiply_negate_file_ops (
    input  wire logic                             clk_sys,          // System clock.
    input  wire logic                             rst_n,            // Sync reset, low.
    input  wire logic [mul_neg_pkg::BUS_AW-1:0]   avs_address,      // Byte address.
    input  wire logic                             avs_read,         // Read request.
    input  wire logic                             avs_write,        // Write request.
    input  wire logic [31:0]                      avs_writedata,    // Write data.
    output logic      [31:0]                      avs_readdata,     // Read data.
    output logic                                  avs_waitrequest   // Stall.
);
    import mul_neg_pkg::*;

    localparam int MEM_DEPTH = 1 << ADDR_W;

    logic [DATA_W-1:0] data_mem [MEM_DEPTH];

    phase_t             phase_q,      phase_d;
    logic [INSTR_W-1:0] instr_q,      instr_d;
    logic [DATA_W-1:0]  wreg_q,       wreg_d;
    logic [BANK_W-1:0]  bank_q,       bank_d;
    logic [ADDR_W-1:0]  index_q,      index_d;
    logic               ext_en_q,     ext_en_d;
    logic [FLAG_W-1:0]  flags_q,      flags_d;
    logic [DATA_W-1:0]  prod_hi_q,    prod_hi_d;
    logic [DATA_W-1:0]  prod_lo_q,    prod_lo_d;
    logic [ADDR_W-1:0]  maddr_q,      maddr_d;
    logic [ADDR_W-1:0]  opaddr_q,     opaddr_d;
    logic [DATA_W-1:0]  operand_q,    operand_d;
    logic [DATA_W-1:0]  neg_res_q,    neg_res_d;
    logic [FLAG_W-1:0]  neg_flags_q,  neg_flags_d;
    logic [2*DATA_W-1:0] product_q,   product_d;
    logic               rd_ready_q,   rd_ready_d;
    logic [31:0]        rdata_q,      rdata_d;

    logic               busy;
    logic               bus_take;
    logic               mem_we;
    logic [ADDR_W-1:0]  mem_waddr;
    logic [DATA_W-1:0]  mem_wdata;
    logic [DATA_W:0]    neg_sum;
    logic [4:0]         neg_nib;

    operand_addr_if ap ();

    operand_addr_resolve u_resolve (
        .ap (ap)
    );

    // Feed the resolver from the latched instruction and the bank state.
    assign ap.bank_bit   = instr_q[BANK_BIT];
    assign ap.file_addr  = instr_q[DATA_W-1:0];
    assign ap.bank_sel   = bank_q;
    assign ap.ext_en     = ext_en_q;
    assign ap.index_base = index_q;

    // The bus stalls while an instruction runs, and one cycle on reads so
    // that read data always comes from a flip-flop.
    assign busy            = (phase_q != PH_IDLE);
    assign avs_waitrequest = busy || (avs_read && !rd_ready_q);
    assign bus_take        = !avs_waitrequest;
    assign avs_readdata    = rdata_q;

    // Negate arithmetic: inverted byte plus one, with nibble carry.
    assign neg_sum = {1'b0, ~operand_q} + {1'b0, ONE_BYTE};
    assign neg_nib = {1'b0, ~operand_q[3:0]} + {1'b0, ONE_NIB};

    // Phase sequencer: one instruction cycle is Q1 decode, Q2 read,
    // Q3 process and Q4 write, one clock each.
    always_comb begin
        phase_d = phase_q;
        unique case (phase_q)
            PH_IDLE: begin
                if (bus_take && avs_write && avs_address == OFS_INSTR) begin
                    phase_d = PH_Q1;
                end
            end
            PH_Q1:   phase_d = PH_Q2;
            PH_Q2:   phase_d = PH_Q3;
            PH_Q3:   phase_d = PH_Q4;
            PH_Q4:   phase_d = PH_IDLE;
            default: phase_d = PH_IDLE;
        endcase
    end

    // Datapath next values for each phase.
    always_comb begin
        opaddr_d    = opaddr_q;
        operand_d   = operand_q;
        product_d   = product_q;
        neg_res_d   = neg_res_q;
        neg_flags_d = neg_flags_q;
        if (phase_q == PH_Q1) begin
            // Decode: fix the operand address for the read and write phases.
            opaddr_d = ap.data_addr;
        end
        if (phase_q == PH_Q2) begin
            operand_d = data_mem[opaddr_q];
        end
        if (phase_q == PH_Q3) begin
            product_d = (2*DATA_W)'(wreg_q) * (2*DATA_W)'(operand_q);
            neg_res_d = neg_sum[DATA_W-1:0];
            neg_flags_d[FLAG_C]  = neg_sum[DATA_W];
            neg_flags_d[FLAG_DIGIT] = neg_nib[4];
            neg_flags_d[FLAG_Z]  = (neg_sum[DATA_W-1:0] == RST_BYTE);
            neg_flags_d[FLAG_N]  = neg_sum[DATA_W-1];
            // Signed overflow only when the inverted byte is the largest
            // positive value and the increment wraps it negative.
            neg_flags_d[FLAG_OVF] = operand_q[DATA_W-1] && neg_sum[DATA_W-1];
        end
    end

    // Architectural registers: software writes when idle, Q4 writes results.
    always_comb begin
        instr_d   = instr_q;
        wreg_d    = wreg_q;
        bank_d    = bank_q;
        index_d   = index_q;
        ext_en_d  = ext_en_q;
        flags_d   = flags_q;
        prod_hi_d = prod_hi_q;
        prod_lo_d = prod_lo_q;
        maddr_d   = maddr_q;
        if (bus_take && avs_write) begin
            unique case (avs_address)
                OFS_CTRL:   ext_en_d  = avs_writedata[CTRL_EXT_BIT];
                OFS_WREG:   wreg_d    = avs_writedata[DATA_W-1:0];
                OFS_BANK:   bank_d    = avs_writedata[BANK_W-1:0];
                OFS_INDEX:  index_d   = avs_writedata[ADDR_W-1:0];
                OFS_INSTR:  instr_d   = avs_writedata[INSTR_W-1:0];
                OFS_STATUS: flags_d   = avs_writedata[FLAG_W-1:0];
                OFS_PROD_HI: prod_hi_d = avs_writedata[DATA_W-1:0];
                OFS_PROD_LO: prod_lo_d = avs_writedata[DATA_W-1:0];
                OFS_MADDR:  maddr_d   = avs_writedata[ADDR_W-1:0];
                default:    ;
            endcase
        end
        if (phase_q == PH_Q4 && is_mul_file(instr_q)) begin
            // Only the product pair is written; W, source byte and
            // flags stay as they were, even for a zero product.
            prod_hi_d = product_q[2*DATA_W-1:DATA_W];
            prod_lo_d = product_q[DATA_W-1:0];
        end
        if (phase_q == PH_Q4 && is_neg_file(instr_q)) begin
            flags_d = neg_flags_q;
        end
    end

    // Single write port into data memory, shared by software and negate.
    always_comb begin
        mem_we    = 1'b0;
        mem_waddr = maddr_q;
        mem_wdata = avs_writedata[DATA_W-1:0];
        if (bus_take && avs_write && avs_address == OFS_MDATA) begin
            mem_we = 1'b1;
        end
        if (phase_q == PH_Q4 && is_neg_file(instr_q)) begin
            mem_we    = 1'b1;
            mem_waddr = opaddr_q;
            mem_wdata = neg_res_q;
        end
    end

    // Read path: capture data in the stall cycle, release on the next.
    always_comb begin
        rd_ready_d = avs_read && !busy && !rd_ready_q;
        rdata_d    = rdata_q;
        if (avs_read && !busy && !rd_ready_q) begin
            rdata_d = '0;
            unique case (avs_address)
                OFS_CTRL: begin
                    rdata_d[CTRL_EXT_BIT]  = ext_en_q;
                    rdata_d[CTRL_BUSY_BIT] = busy;
                end
                OFS_WREG:   rdata_d[DATA_W-1:0]  = wreg_q;
                OFS_BANK:   rdata_d[BANK_W-1:0]  = bank_q;
                OFS_INDEX:  rdata_d[ADDR_W-1:0]  = index_q;
                OFS_INSTR:  rdata_d[INSTR_W-1:0] = instr_q;
                OFS_STATUS: rdata_d[FLAG_W-1:0]  = flags_q;
                OFS_PROD_HI: rdata_d[DATA_W-1:0] = prod_hi_q;
                OFS_PROD_LO: rdata_d[DATA_W-1:0] = prod_lo_q;
                OFS_MADDR:  rdata_d[ADDR_W-1:0]  = maddr_q;
                OFS_MDATA:  rdata_d[DATA_W-1:0]  = data_mem[maddr_q];
                default:    ;
            endcase
        end
    end

    // Data memory holds no reset; it is written from one port only.
    always_ff @(posedge clk_sys) begin
        if (mem_we) begin
            data_mem[mem_waddr] <= mem_wdata;
        end
    end

    // State registers.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            phase_q     <= PH_IDLE;
            instr_q     <= RST_INSTR;
            wreg_q      <= RST_BYTE;
            bank_q      <= LOW_BANK;
            index_q     <= RST_ADDR;
            ext_en_q    <= 1'b0;
            flags_q     <= RST_FLAGS;
            prod_hi_q   <= RST_BYTE;
            prod_lo_q   <= RST_BYTE;
            maddr_q     <= RST_ADDR;
            opaddr_q    <= RST_ADDR;
            operand_q   <= RST_BYTE;
            neg_res_q   <= RST_BYTE;
            neg_flags_q <= RST_FLAGS;
            product_q   <= '0;
            rd_ready_q  <= 1'b0;
            rdata_q     <= '0;
        end else begin
            phase_q     <= phase_d;
            instr_q     <= instr_d;
            wreg_q      <= wreg_d;
            bank_q      <= bank_d;
            index_q     <= index_d;
            ext_en_q    <= ext_en_d;
            flags_q     <= flags_d;
            prod_hi_q   <= prod_hi_d;
            prod_lo_q   <= prod_lo_d;
            maddr_q     <= maddr_d;
            opaddr_q    <= opaddr_d;
            operand_q   <= operand_d;
            neg_res_q   <= neg_res_d;
            neg_flags_q <= neg_flags_d;
            product_q   <= product_d;
            rd_ready_q  <= rd_ready_d;
            rdata_q     <= rdata_d;
        end
    end

endmodule
`default_nettype wire

//--- hw/mul_neg_pkg.sv
/*
 * Constants, types and decode helpers for the multiply and negate datapath.
 * Assumes a 10 MHz clk_sys, a 12-bit data address space and a 32-bit
 * Avalon-MM slave port for software access.
 */
// How it works
// - Register multiply forms the unsigned W times file byte into the 16-bit product pair.
// - Upper product byte goes to product high, lower byte to product low.
// - Register multiply writes neither W nor the source byte, only the product pair.
// - Register multiply changes no status flag, even for a zero product.
// - Bank bit 0 selects the access bank; bank bit 1 uses the bank select register.
// - Bank bit 0, extended set on and address up to 95 use indexed literal offset.
// - Negate forms inverted byte plus one and updates negative, overflow, carry, digit carry, zero.
// - Negate writes its result back into the same data memory location.
package mul_neg_pkg;

    localparam int DATA_W   = 8;
    localparam int ADDR_W   = 12;
    localparam int BANK_W   = 4;
    localparam int INSTR_W  = 16;
    localparam int BUS_AW   = 6;

    // Register byte offsets on the slave port.
    localparam logic [BUS_AW-1:0] OFS_CTRL   = 6'h00;
    localparam logic [BUS_AW-1:0] OFS_WREG   = 6'h04;
    localparam logic [BUS_AW-1:0] OFS_BANK   = 6'h08;
    localparam logic [BUS_AW-1:0] OFS_INDEX  = 6'h0c;
    localparam logic [BUS_AW-1:0] OFS_INSTR  = 6'h10;
    localparam logic [BUS_AW-1:0] OFS_STATUS = 6'h14;
    localparam logic [BUS_AW-1:0] OFS_PROD_HI = 6'h18;
    localparam logic [BUS_AW-1:0] OFS_PROD_LO = 6'h1c;
    localparam logic [BUS_AW-1:0] OFS_MADDR  = 6'h20;
    localparam logic [BUS_AW-1:0] OFS_MDATA  = 6'h24;

    // Control register fields.
    localparam int CTRL_EXT_BIT  = 0;
    localparam int CTRL_BUSY_BIT = 1;

    // Status flag positions.
    localparam int FLAG_C  = 0;
    localparam int FLAG_DIGIT = 1;
    localparam int FLAG_Z     = 2;
    localparam int FLAG_OVF   = 3;
    localparam int FLAG_N  = 4;
    localparam int FLAG_W  = 5;

    // Instruction layout: opcode in bits 15..9, bank bit 8, file address 7..0.
    localparam int OPC_HI   = 15;
    localparam int OPC_LO   = 9;
    localparam int BANK_BIT = 8;
    localparam logic [6:0] OPC_MUL_FILE = 7'h01;
    localparam logic [6:0] OPC_NEG_FILE = 7'h36;

    // Addressing limits.
    localparam logic [DATA_W-1:0] LIT_OFS_MAX  = 8'h5f;
    localparam logic [DATA_W-1:0] ACCESS_SPLIT = 8'h60;
    localparam logic [BANK_W-1:0] SFR_BANK     = 4'hf;
    localparam logic [BANK_W-1:0] LOW_BANK     = 4'h0;

    // Reset values and increment constants.
    localparam logic [DATA_W-1:0]  RST_BYTE  = 8'h00;
    localparam logic [ADDR_W-1:0]  RST_ADDR  = 12'h000;
    localparam logic [INSTR_W-1:0] RST_INSTR = 16'h0000;
    localparam logic [FLAG_W-1:0]  RST_FLAGS = 5'h00;
    localparam logic [DATA_W-1:0]  ONE_BYTE  = 8'h01;
    localparam logic [3:0]         ONE_NIB   = 4'h1;

    // Phase sequence, Gray coded along idle, Q1, Q2, Q3, Q4.
    typedef enum logic [2:0] {
        PH_IDLE = 3'h0,
        PH_Q1   = 3'h1,
        PH_Q2   = 3'h3,
        PH_Q3   = 3'h2,
        PH_Q4   = 3'h6
    } phase_t;

    function automatic logic is_mul_file(input logic [INSTR_W-1:0] ins);
        return ins[OPC_HI:OPC_LO] == OPC_MUL_FILE;
    endfunction

    function automatic logic is_neg_file(input logic [INSTR_W-1:0] ins);
        return ins[OPC_HI:OPC_LO] == OPC_NEG_FILE;
    endfunction

endpackage

//--- hw/operand_addr_if.sv
/*
 * Carrier between the core sequencer and the operand address resolver.
 * Assumes both ends sit on the same clock; the path is purely combinational.
 */
`timescale 1ns/100ps
`default_nettype none
interface operand_addr_if;
    import mul_neg_pkg::*;
    logic              bank_bit;
    logic [DATA_W-1:0] file_addr;
    logic [BANK_W-1:0] bank_sel;
    logic              ext_en;
    logic [ADDR_W-1:0] index_base;
    logic [ADDR_W-1:0] data_addr;
    logic              indexed;

    modport core (output bank_bit, file_addr, bank_sel, ext_en, index_base,
                  input data_addr, indexed);
    modport resolver (input bank_bit, file_addr, bank_sel, ext_en, index_base,
                      output data_addr, indexed);
endinterface
`default_nettype wire

//--- hw/operand_addr_resolve.sv
/*
 * Turns the bank bit and 8-bit file address of an instruction into a
 * 12-bit data memory address. Assumes the caller holds its inputs stable.
 */
`timescale 1ns/100ps
`default_nettype none
module operand_addr_resolve (
    operand_addr_if.resolver ap    // Address request and answer.
);
    import mul_neg_pkg::*;

    // Pick indexed, access bank or banked addressing.
    always_comb begin
        ap.indexed   = 1'b0;
        ap.data_addr = {ap.bank_sel, ap.file_addr};
        if (!ap.bank_bit) begin
            if (ap.ext_en && ap.file_addr <= LIT_OFS_MAX) begin
                // Base plus literal offset wraps inside the data space.
                ap.indexed   = 1'b1;
                ap.data_addr = ADDR_W'(ap.index_base + {4'h0, ap.file_addr});
            end else if (ap.file_addr < ACCESS_SPLIT) begin
                ap.data_addr = {LOW_BANK, ap.file_addr};
            end else begin
                ap.data_addr = {SFR_BANK, ap.file_addr};
            end
        end
    end

endmodule
`default_nettype wire

//--- dv/multiply_negate_file_ops_sva.sv
/*
 * Bus-side assertions for the multiply and negate slice.
 * Assumes it is bound to the top module and sees only its ports.
 */
`timescale 1ns/100ps
`default_nettype none
module multiply_negate_file_ops_sva
    import mul_neg_pkg::*;
(
    input wire logic              clk_sys,         // Clock.
    input wire logic              rst_n,           // Sync reset, low.
    input wire logic [BUS_AW-1:0] avs_address,     // Byte address.
    input wire logic              avs_read,        // Read request.
    input wire logic              avs_write,       // Write request.
    input wire logic [31:0]       avs_writedata,   // Write data.
    input wire logic [31:0]       avs_readdata,    // Read data.
    input wire logic              avs_waitrequest  // Stall.
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);
    // A read that the slave finishes in this cycle.
    logic rd_end;
    assign rd_end = avs_read && !avs_waitrequest;

    property p_instr_busy;
        avs_write && !avs_waitrequest && avs_address == OFS_INSTR
            |=> avs_waitrequest [*4] ##1 (avs_read || !avs_waitrequest);
    endproperty
    a_instr_busy: assert property (p_instr_busy)
        else $error("Instruction stall is not four cycles.");
    property p_read_answer;
        avs_read && avs_waitrequest |-> ##[1:6] !avs_waitrequest;
    endproperty
    a_read_answer: assert property (p_read_answer)
        else $error("Read not answered in time.");
    property p_read_late;
        rd_end |-> $past(avs_read);
    endproperty
    a_read_late: assert property (p_read_late)
        else $error("Read answered in its first cycle.");
    property p_rdata_hold;
        $changed(avs_readdata) |-> $past(avs_read);
    endproperty
    a_rdata_hold: assert property (p_rdata_hold)
        else $error("Read data changed without a read.");
    property p_unmapped;
        rd_end && (avs_address[1:0] != 2'h0 || avs_address > OFS_MDATA) |-> avs_readdata == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("Unmapped read not zero.");
    property p_prod_hi;
        rd_end && avs_address == OFS_PROD_HI |-> avs_readdata[31:8] == 24'h0;
    endproperty
    a_prod_hi: assert property (p_prod_hi)
        else $error("Product high wider than a byte.");
    property p_status;
        rd_end && avs_address == OFS_STATUS |-> avs_readdata[31:5] == 27'h0;
    endproperty
    a_status: assert property (p_status)
        else $error("Status has stray bits.");
    property p_ctrl;
        rd_end && avs_address == OFS_CTRL |-> avs_readdata[31:1] == 31'h0;
    endproperty
    a_ctrl: assert property (p_ctrl)
        else $error("Control reads busy or stray bits.");
endmodule
bind multiply_negate_file_ops multiply_negate_file_ops_sva chk (.clk_sys(clk_sys),
    .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest));
`default_nettype wire

//--- dv/multiply_negate_file_ops_test.sv
/*
 * Self-checking bench for the multiply and negate slice.
 * Assumes the package is compiled first and the checker is bound.
 */
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin miscompares++; \
    $display("Error t=%0t got %h exp %h", $time, (g), (e)); end end
module multiply_negate_file_ops_test;
    import mul_neg_pkg::*;
    logic              clk_sys, rst_n, avs_read, avs_write, avs_waitrequest;
    logic [BUS_AW-1:0] avs_address;
    logic [31:0]       avs_writedata, avs_readdata, rv, seed;
    logic [4:0]        st;
    int                checked, miscompares;

    multiply_negate_file_ops uut (.clk_sys(clk_sys), .rst_n(rst_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    // Where an operand should land, from the bank bit and mode.
    function automatic logic [11:0] map_addr(logic a, logic [7:0] f, logic ext,
                                             logic [3:0] bank, logic [11:0] base);
        if (a) return {bank, f};
        if (ext && f <= LIT_OFS_MAX) return base + {4'h0, f};
        return (f < ACCESS_SPLIT) ? {4'h0, f} : {SFR_BANK, f};
    endfunction
    // Negate flags in the order N, OV, Z, DC, C.
    function automatic logic [4:0] nflags(logic [7:0] v);
        logic [7:0] r;
        r = ~v + 8'h01;
        return {r[7], v == 8'h80, r == 8'h00, v[3:0] == 4'h0, v == 8'h00};
    endfunction
    // One bus cycle, held until waitrequest is sampled low at a rising edge;
    // read data is taken and the request released at that same edge.
    task automatic bus(input logic wr, input logic [BUS_AW-1:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        avs_address   <= a;
        avs_write     <= wr;
        avs_read      <= !wr;
        avs_writedata <= d;
        @(posedge clk_sys);
        while (avs_waitrequest !== 1'b0) @(posedge clk_sys);
        rv = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
    endtask
    // Loads all operands, then launches one instruction.
    task automatic run(input logic [15:0] ins, input logic [7:0] w, v, input logic ext,
                       input logic [11:0] base);
        logic [3:0] bank;
        bank = 4'(rnd());
        st = 5'(rnd());
        bus(1, OFS_CTRL, {31'h0, ext});
        bus(1, OFS_BANK, {28'h0, bank});
        bus(1, OFS_INDEX, {20'h0, base});
        bus(1, OFS_WREG, {24'h0, w});
        bus(1, OFS_STATUS, {27'h0, st});
        bus(1, OFS_MADDR, {20'h0, map_addr(ins[8], ins[7:0], ext, bank, base)});
        bus(1, OFS_MDATA, {24'h0, v});
        bus(1, OFS_INSTR, {16'h0, ins});
    endtask
    task automatic mul(input logic [7:0] w, v, input logic a);
        logic [15:0] p;
        p = 16'(w) * 16'(v);
        run({OPC_MUL_FILE, a, 8'(rnd())}, w, v, 1'(rnd()), 12'(rnd()));
        bus(0, OFS_PROD_HI, 32'h0);
        `CHK(rv, {24'h0, p[15:8]})
        bus(0, OFS_PROD_LO, 32'h0);
        `CHK(rv, {24'h0, p[7:0]})
        bus(0, OFS_WREG, 32'h0);
        `CHK(rv, {24'h0, w})
        bus(0, OFS_MDATA, 32'h0);
        `CHK(rv, {24'h0, v})
        bus(0, OFS_STATUS, 32'h0);
        `CHK(rv, {27'h0, st})
    endtask
    task automatic neg(input logic [7:0] v, f, input logic a, ext, input logic [11:0] base);
        logic [7:0] r;
        r = ~v + 8'h01;
        run({OPC_NEG_FILE, a, f}, 8'(rnd()), v, ext, base);
        bus(0, OFS_MDATA, 32'h0);
        `CHK(rv, {24'h0, r})
        bus(0, OFS_STATUS, 32'h0);
        `CHK(rv, {27'h0, nflags(v)})
    endtask
    task automatic conclude();
        $display("Checked %0d, miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    // Watchdog well beyond the expected thousand or so cycles.
    initial begin
        repeat (20000) @(posedge clk_sys);
        miscompares++;
        conclude();
    end
    // Reset values, unmapped places, then corner and random instructions.
    initial begin
        rst_n = 1'b0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_address = '0;
        avs_writedata = '0;
        seed = 32'd58;
        checked = 0;
        miscompares = 0;
        repeat (8) @(posedge clk_sys);
        rst_n <= 1'b1;
        for (int i = 0; i < 9; i++) begin
            bus(0, 6'(i * 4), 32'h0);
            `CHK(rv, 32'h0)
        end
        bus(1, 6'h28, rnd());
        for (int i = 0; i < 3; i++) begin
            bus(0, 6'(40 + i * 5), 32'h0);
            `CHK(rv, 32'h0)
        end
        mul(8'hc4, 8'hb5, 1'b1);
        mul(8'h00, 8'h7e, 1'b0);
        mul(8'hff, 8'hff, 1'b1);
        for (int i = 0; i < 12; i++) mul(8'(rnd()), 8'(rnd()), 1'(rnd()));
        neg(8'h3a, 8'h10, 1'b1, 1'b0, 12'h000);
        neg(8'h00, 8'h5f, 1'b0, 1'b1, 12'hfd0);
        neg(8'h80, 8'h60, 1'b0, 1'b1, 12'h100);
        neg(8'h10, 8'h5f, 1'b0, 1'b0, 12'h123);
        neg(8'h7f, 8'h00, 1'b0, 1'b1, 12'h123);
        for (int i = 0; i < 12; i++) neg(8'(rnd()), 8'(rnd()), 1'(rnd()), 1'(rnd()), 12'(rnd()));
        conclude();
    end
endmodule
`default_nettype wire
